// ===== logic/dcb_pkg.sv
// constants, command codes and carriers for the ddr2 command and bank logic
// assumes a single core_clk domain; link clock and pins arrive unsynchronised
// Behaviour
// - write burst stores bytes whose mask is low, keeps bytes whose mask is high
// - chip select high takes no new command, running work continues
// - selected cycle with row, column and write strobes high is a no-operation
// - mode-load picks the mode register by bank select, loads it from address
// - activate opens the addressed row in the selected bank until precharge
// - read takes bank from bank select and start column from low ten address bits
// - write starts a burst at the low ten address bits in the selected bank
// - autoprecharge flag line closes the row at burst end, else row stays open
// - early read or write is held internally for the additive latency in cycles
// - precharge closes one or all banks, activate waits the precharge period
// - access to another bank is accepted while one bank auto-precharges
// - precharge to idle or precharging bank accepted, period restarts from it
// - refresh rows come from an internal counter, address inputs ignored
// - refresh encoding with clock gate low enters self refresh, data retained
// - edge align loop is off in self refresh and back on at exit
// - termination set by extended mode-set, switched by termination enable
// - termination works in active, standby, power-down, never in self refresh; term_lane_ff stays on for one core_clk cycle after entry
// - termination covers data, strobes, mask and read strobes of the width option
// - termination latencies met means non-power-down termination timing
// - latencies not met, as in precharge power-down, means power-down timing
// - commands decode from select, strobes and clock gate at the rising link edge
package dcb_pkg;
  localparam int NUM_BANKS       = 8;
  localparam int BANK_W          = 3;
  localparam int ADDR_W          = 14;
  localparam int COL_W           = 10;
  localparam int AP_BIT          = 10;
  localparam int NUM_MODE_REGS   = 4;
  localparam int PRECHARGE_PERIOD_CK = 5;
  localparam int BURST_LEN_CK    = 2;
  localparam int SELFEXIT_READ_CK = 200;
  localparam int REFRESH_CNT_W   = 13;
  localparam logic [ADDR_W-1:0] MODE_RESET = 14'h0000;

  typedef enum logic [1:0] {
    DCB_IDLE  = 2'b00,
    DCB_OPEN  = 2'b01,
    DCB_PRECH = 2'b10
  } dcb_bank_t;

  typedef enum logic [3:0] {
    DCB_C_DESEL = 4'h0, DCB_C_NOP  = 4'h1, DCB_C_MODE = 4'h2, DCB_C_REF  = 4'h3,
    DCB_C_SREF  = 4'h4, DCB_C_PRE  = 4'h5, DCB_C_ACT  = 4'h6, DCB_C_WR   = 4'h7,
    DCB_C_RD    = 4'h8, DCB_C_ILL  = 4'h9
  } dcb_cmd_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } dcb_cmd_pins_t;

  typedef struct packed {
    logic              valid;
    logic              wr;
    logic              ap;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
  } dcb_access_t;
endpackage

// ===== logic/dcb_top.sv
// command decode, per-bank state, additive latency, masked write and termination control
// assumes link clock and command pins are asynchronous to core_clk and much slower
`timescale 1ns/1ps
`default_nettype none
module dcb_top #(
  parameter int DATA_W = 16,
  parameter int MAX_AL = 5
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // link clock and command pins
  input  wire logic                       link_clk,
  input  wire dcb_pkg::dcb_cmd_pins_t     cmd_pins,
  input  wire logic                       termination_enable,
  // write data with byte mask
  input  wire logic [DATA_W-1:0]          wr_data,
  input  wire logic [DATA_W/8-1:0]        byte_write_mask,
  // settings
  input  wire logic [2:0]                 additive_latency,
  input  wire logic                       term_pd_latency_met,
  // state and results
  output logic [2*dcb_pkg::NUM_BANKS-1:0] bank_state_ff,
  output logic                            edge_align_loop_ff,
  output logic                            self_refresh_ff,
  output logic                            term_active_ff,
  output logic                            term_pd_timing_ff,
  output logic [DATA_W/8-1:0]             term_lane_ff,
  output logic [dcb_pkg::REFRESH_CNT_W-1:0] refresh_row_ff,
  output logic                            illegal_cmd_ff,
  output dcb_pkg::dcb_access_t            access_ff,
  output logic [DATA_W-1:0]               stored_word_ff,
  output logic [dcb_pkg::ADDR_W-1:0]      mode_reg1_ff
);
  import dcb_pkg::*;

  // elaboration-time refusal of widths and depths the logic cannot serve
  if (DATA_W != 8 && DATA_W != 16) begin : g_bad_width
    $error("DATA_W must be 8 or 16");
  end
  if (MAX_AL < 1 || MAX_AL > 7) begin : g_bad_al
    $error("MAX_AL out of range");
  end

  // two-stage synchronisers; stage one feeds stage two only
  logic                clk_s1_ff, clk_s2_ff, clk_s3_ff;
  dcb_cmd_pins_t       pins_s1_ff, pins_s2_ff;
  logic                term_s1_ff, term_s2_ff;
  logic [DATA_W-1:0]   data_s1_ff, data_s2_ff;
  logic [DATA_W/8-1:0] mask_s1_ff, mask_s2_ff;

  always_ff @(posedge core_clk) begin
    clk_s1_ff  <= link_clk;
    clk_s2_ff  <= clk_s1_ff;
    clk_s3_ff  <= clk_s2_ff;
    pins_s1_ff <= cmd_pins;
    pins_s2_ff <= pins_s1_ff;
    term_s1_ff <= termination_enable;
    term_s2_ff <= term_s1_ff;
    data_s1_ff <= wr_data;
    data_s2_ff <= data_s1_ff;
    mask_s1_ff <= byte_write_mask;
    mask_s2_ff <= mask_s1_ff;
  end

  // a rising link edge is the sampling instant; pins lag the clock by the same two stages
  wire link_rise = clk_s2_ff & ~clk_s3_ff;

  logic cke_prev_ff;
  wire  cke_now = pins_s2_ff.cke;

  function automatic dcb_cmd_t decode(input dcb_cmd_pins_t p, input logic cke_prev);
    logic [3:0] s;
    s = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
    if (!cke_prev) decode = DCB_C_NOP;
    else if (p.cs_n) decode = DCB_C_DESEL;
    else begin
      unique case (s[2:0])
        3'b111: decode = DCB_C_NOP;
        3'b000: decode = p.cke ? DCB_C_MODE : DCB_C_ILL;
        3'b001: decode = p.cke ? DCB_C_REF : DCB_C_SREF;
        3'b010: decode = DCB_C_PRE;
        3'b011: decode = DCB_C_ACT;
        3'b100: decode = DCB_C_WR;
        3'b101: decode = DCB_C_RD;
        default: decode = DCB_C_ILL;
      endcase
    end
  endfunction

  wire dcb_cmd_t cmd     = link_rise ? decode(pins_s2_ff, cke_prev_ff) : DCB_C_NOP;
  wire [BANK_W-1:0] bsel = pins_s2_ff.bank;
  wire [ADDR_W-1:0] addr = pins_s2_ff.addr;

  // per-bank state and precharge timers
  dcb_bank_t bank_ff [NUM_BANKS];
  logic [2:0] pre_cnt_ff [NUM_BANKS];
  logic [NUM_BANKS-1:0] ap_pend_ff;
  logic [ADDR_W-1:0] open_row_ff [NUM_BANKS];

  wire bank_open = (bank_ff[bsel] == DCB_OPEN);
  logic all_idle;
  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) if (bank_ff[i] != DCB_IDLE) all_idle = 1'b0;
  end

  wire cmd_wr_ok = (cmd == DCB_C_WR) & bank_open;
  wire cmd_rd_ok = (cmd == DCB_C_RD) & bank_open;
  wire cmd_bad   = (cmd == DCB_C_ILL) | ((cmd == DCB_C_WR | cmd == DCB_C_RD) & ~bank_open)
                 | ((cmd == DCB_C_ACT) & (bank_ff[bsel] != DCB_IDLE));

  // additive latency shift line: accesses are held, then registered internally
  dcb_access_t al_pipe_ff [MAX_AL+1];
  dcb_access_t al_in;
  assign al_in.valid = cmd_wr_ok | cmd_rd_ok;
  assign al_in.wr    = cmd_wr_ok;
  assign al_in.ap    = addr[AP_BIT];
  assign al_in.bank  = bsel;
  assign al_in.col   = addr[COL_W-1:0];
  wire dcb_access_t al_out = al_pipe_ff[additive_latency];

  // burst end timer per bank drives auto-precharge
  logic [1:0] burst_cnt_ff [NUM_BANKS];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cke_prev_ff <= 1'b1;
      for (int i = 0; i <= MAX_AL; i++) al_pipe_ff[i] <= '0;
    end else begin
      if (link_rise) cke_prev_ff <= cke_now;
      if (link_rise) begin
        al_pipe_ff[0] <= al_in;
        for (int i = 1; i <= MAX_AL; i++) al_pipe_ff[i] <= al_pipe_ff[i-1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        bank_ff[i]      <= DCB_IDLE;
        pre_cnt_ff[i]   <= 3'h0;
        burst_cnt_ff[i] <= 2'h0;
        open_row_ff[i]  <= '0;
      end
      ap_pend_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        logic hit;
        hit = (bsel == BANK_W'(i));
        if (cmd == DCB_C_ACT && hit && bank_ff[i] == DCB_IDLE) begin
          bank_ff[i]     <= DCB_OPEN;
          open_row_ff[i] <= addr;
        end else if (cmd == DCB_C_PRE && (hit || addr[AP_BIT])) begin
          bank_ff[i]    <= DCB_PRECH;
          pre_cnt_ff[i] <= 3'(PRECHARGE_PERIOD_CK);
          ap_pend_ff[i] <= 1'b0;
        end else if (ap_pend_ff[i] && link_rise && burst_cnt_ff[i] == 2'h0) begin
          bank_ff[i]    <= DCB_PRECH;
          pre_cnt_ff[i] <= 3'(PRECHARGE_PERIOD_CK);
          ap_pend_ff[i] <= 1'b0;
        end else if (bank_ff[i] == DCB_PRECH && link_rise) begin
          if (pre_cnt_ff[i] == 3'h1) bank_ff[i] <= DCB_IDLE;
          pre_cnt_ff[i] <= pre_cnt_ff[i] - 3'h1;
        end
        if (al_out.valid && al_out.bank == BANK_W'(i) && link_rise) begin
          burst_cnt_ff[i] <= 2'(BURST_LEN_CK);
          if (al_out.ap) ap_pend_ff[i] <= 1'b1;
        end else if (link_rise && burst_cnt_ff[i] != 2'h0) begin
          burst_cnt_ff[i] <= burst_cnt_ff[i] - 2'h1;
        end
      end
    end
  end

  // mode registers; bank select chooses which
  logic [ADDR_W-1:0] mode_ff [NUM_MODE_REGS];
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_MODE_REGS; i++) mode_ff[i] <= MODE_RESET;
    end else if (cmd == DCB_C_MODE && all_idle) begin
      mode_ff[bsel[1:0]] <= addr;
    end
  end

  // masked write into a held word; the array proper sits outside this block
  logic [DATA_W-1:0] nxt_word;
  always_comb begin
    nxt_word = stored_word_ff;
    for (int b = 0; b < DATA_W/8; b++)
      if (!mask_s2_ff[b]) nxt_word[b*8 +: 8] = data_s2_ff[b*8 +: 8];
  end

  // self refresh, refresh counter, edge align loop
  wire sref_enter = (cmd == DCB_C_SREF) & all_idle;
  wire sref_exit  = self_refresh_ff & link_rise & cke_now & ~cke_prev_ff;

  // termination state; precharge power-down misses the latencies
  wire pd_now  = ~cke_now & ~self_refresh_ff;
  wire pd_slow = pd_now & (all_idle | ~term_pd_latency_met);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stored_word_ff     <= '0;
      refresh_row_ff     <= '0;
      self_refresh_ff    <= 1'b0;
      edge_align_loop_ff <= 1'b1;
      term_active_ff     <= 1'b0;
      term_pd_timing_ff  <= 1'b0;
      term_lane_ff       <= '0;
      illegal_cmd_ff     <= 1'b0;
      access_ff          <= '0;
    end else begin
      if (link_rise && al_out.valid && al_out.wr) stored_word_ff <= nxt_word;
      if ((cmd == DCB_C_REF && all_idle) || sref_enter)
        refresh_row_ff <= refresh_row_ff + 1'b1;
      if (sref_enter) begin
        self_refresh_ff    <= 1'b1;
        edge_align_loop_ff <= 1'b0;
      end else if (sref_exit) begin
        self_refresh_ff    <= 1'b0;
        edge_align_loop_ff <= 1'b1;
      end
      term_active_ff    <= term_s2_ff & ~self_refresh_ff & ~sref_enter;
      term_pd_timing_ff <= pd_slow;
      term_lane_ff      <= {(DATA_W/8){term_s2_ff & ~self_refresh_ff}};
      if (link_rise) illegal_cmd_ff <= cmd_bad;
      if (link_rise) access_ff <= al_out;
    end
  end

  assign mode_reg1_ff = mode_ff[1];

  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) bank_state_ff[2*i +: 2] = bank_ff[i];
  end

  // assertions
  sequence pre_issued_s(int k);
    cmd == DCB_C_PRE && (bsel == BANK_W'(k) || addr[AP_BIT]);
  endsequence

  property bank_precharges_p;
    @(posedge core_clk) disable iff (sys_rst)
      pre_issued_s(0) |=> bank_ff[0] == DCB_PRECH;
  endproperty

  pre_closes_bank_a:    assert property (bank_precharges_p) else $error("precharge did not close bank");
  act_opens_bank_a:     assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd == DCB_C_ACT && bsel == 3'h0 && bank_ff[0] == DCB_IDLE) |=> bank_ff[0] == DCB_OPEN)
    else $error("activate did not open row");
  sref_loop_off_a:      assert property (@(posedge core_clk) disable iff (sys_rst)
    self_refresh_ff |-> !edge_align_loop_ff) else $error("edge align loop on in self refresh");
  sref_no_term_a:       assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(self_refresh_ff) && self_refresh_ff |-> !term_active_ff) else $error("termination in self refresh");
  desel_no_change_a:    assert property (@(posedge core_clk) disable iff (sys_rst)
    (link_rise && cke_prev_ff && pins_s2_ff.cs_n) |=> $stable(refresh_row_ff) && !illegal_cmd_ff)
    else $error("deselect acted as command");
  nop_no_change_a:      assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd == DCB_C_NOP) |=> $stable(refresh_row_ff)) else $error("nop disturbed state");
  wr_closed_ignored_a:  assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd == DCB_C_WR && !bank_open) |-> !al_in.valid) else $error("write to closed bank accepted");
  refresh_counts_a:     assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd == DCB_C_REF && all_idle) |=> refresh_row_ff == $past(refresh_row_ff) + 1'b1)
    else $error("refresh counter did not step");
  mode_load_a:          assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd == DCB_C_MODE && all_idle && bsel[1:0] == 2'h1) |=> mode_reg1_ff == $past(addr))
    else $error("mode register not loaded");
endmodule
`default_nettype wire

// ===== test/dcb_ctrl_model.sv
// controller model: drives the link clock and the command pins
// assumes core_clk paces it; one command per link period of at least nine core_clk cycles
`timescale 1ns/1ps
`default_nettype none
module dcb_ctrl_model (
  // pacing clock
  input  wire logic                  core_clk,
  // link side
  output var  logic                  link_clk,
  output var  dcb_pkg::dcb_cmd_pins_t cmd_pins
);
  import dcb_pkg::*;
  initial begin
    link_clk = 1'b0;
    cmd_pins = {4'h7, 1'b1, 3'h0, 14'h0000};
  end
  // pins settle four core_clk cycles before the rising edge so the sampler never sees a mix
  task automatic send(input logic [3:0] strobes_n, input logic cke, input logic [2:0] bank,
                      input logic [13:0] addr);
    @(posedge core_clk);
    link_clk <= 1'b0;
    cmd_pins <= {strobes_n, cke, bank, addr};
    repeat (4) @(posedge core_clk);
    link_clk <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== test/dcb_top_bench.sv
// self-checking bench for the command and bank logic
// assumes dcb_ctrl_model drives the link; the bench owns the remaining inputs
`timescale 1ns/1ps
`default_nettype none
module dcb_top_bench;
  import dcb_pkg::*;
  localparam logic [3:0] C_MODE = 4'h0, C_REF = 4'h1, C_PRE = 4'h2, C_ACT = 4'h3;
  localparam logic [3:0] C_WR = 4'h4, C_RD = 4'h5, C_NOP = 4'h7, C_DES = 4'hb;
  logic           core_clk, sys_rst, termination_enable, term_pd_latency_met;
  logic [15:0]    wr_data, bank_state, word, d, d0, w;
  logic [1:0]     byte_write_mask, lanes;
  logic [2:0]     additive_latency, b;
  logic           link_clk, illegal, loop_on, self_ref, term_on, term_pd;
  dcb_cmd_pins_t  cmd_pins;
  dcb_access_t    acc;
  logic [12:0]    ref_row, r0;
  logic [13:0]    mr1;
  logic [9:0]     c;
  int             bad_count, n_compared, cycles, seed, al;

  dcb_ctrl_model i_model (.core_clk(core_clk), .link_clk(link_clk), .cmd_pins(cmd_pins));
  dcb_top #(.DATA_W(16), .MAX_AL(5)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk), .cmd_pins(cmd_pins),
    .termination_enable(termination_enable), .wr_data(wr_data), .byte_write_mask(byte_write_mask),
    .additive_latency(additive_latency), .term_pd_latency_met(term_pd_latency_met),
    .bank_state_ff(bank_state), .edge_align_loop_ff(loop_on), .self_refresh_ff(self_ref),
    .term_active_ff(term_on), .term_pd_timing_ff(term_pd), .term_lane_ff(lanes),
    .refresh_row_ff(ref_row), .illegal_cmd_ff(illegal), .access_ff(acc), .stored_word_ff(word),
    .mode_reg1_ff(mr1));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic setin(input logic [15:0] dd, input logic [1:0] m, input logic [2:0] a, input logic te,
                       input logic met);
    @(posedge core_clk);
    wr_data <= dd;
    byte_write_mask <= m;
    additive_latency <= a;
    termination_enable <= te;
    term_pd_latency_met <= met;
  endtask
  // two falling edges let the synchroniser and state update land before sampling
  task automatic cmd(input logic [3:0] s, input logic [2:0] bk, input logic [13:0] a, input logic ck = 1'b1);
    i_model.send(s, ck, bk, a);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic nops(input int n);
    repeat (n) cmd(C_NOP, 3'h0, 14'h0000);
  endtask
  function automatic logic [1:0] st(input logic [2:0] bk);
    return bank_state[2*bk +: 2];
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] m);
    for (int k = 0; k < 2; k++) begin
      if (!m[k]) old[8*k +: 8] = nw[8*k +: 8];
    end
    return old;
  endfunction

  initial begin
    seed = 16613;
    sys_rst = 1'b1;
    wr_data = 16'h0000;
    byte_write_mask = 2'b00;
    additive_latency = 3'h0;
    termination_enable = 1'b0;
    term_pd_latency_met = 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    cmd(C_MODE, 3'd1, 14'h1a5c);
    check(mr1, 14'h1a5c);
    cmd(C_MODE, 3'd2, 14'h0333);
    nops(2);
    check(mr1, 14'h1a5c);
    for (int i = 0; i < 6; i++) begin
      b = $random(seed);
      c = $random(seed);
      d = $random(seed);
      d0 = $random(seed);
      al = {$random(seed)} % 6;
      setin(d0, 2'b00, al[2:0], 1'b0, 1'b1);
      cmd(C_ACT, b, d[13:0]);
      check(st(b), 2'b01);
      cmd(C_WR, b, {4'h0, c});
      nops(al);
      check(acc === {3'b110, b, c}, 1'b0);
      nops(1);
      check(acc, {3'b110, b, c});
      check(word, d0);
      setin(d, 2'b10, al[2:0], 1'b0, 1'b1);
      cmd(C_WR, b, {4'h0, c});
      nops(al + 1);
      w = merge(d0, d, 2'b10);
      check(word, w);
      check(st(b), 2'b01);
      cmd(C_RD, b, {4'h1, c});
      nops(al + 1);
      check(acc, {3'b101, b, c});
      nops(8);
      check(st(b), 2'b00);
      cmd(C_WR, b, {4'h0, c});
      check(illegal, 1'b1);
      nops(al + 1);
      check(word, w);
    end
    setin(16'h0000, 2'b00, 3'h0, 1'b0, 1'b1);
    cmd(C_ACT, 3'd3, 14'h0001);
    cmd(C_ACT, 3'd3, 14'h0002);
    check(illegal, 1'b1);
    cmd(C_PRE, 3'd3, 14'h0000);
    check(st(3'd3), 2'b10);
    nops(3);
    cmd(C_PRE, 3'd3, 14'h0000);
    nops(3);
    check(st(3'd3), 2'b10);
    nops(4);
    check(st(3'd3), 2'b00);
    cmd(C_ACT, 3'd0, 14'h0011);
    cmd(C_ACT, 3'd5, 14'h0022);
    cmd(C_DES, 3'd4, 14'h0033);
    check(st(3'd4), 2'b00);
    cmd(C_PRE, 3'd0, 14'h0400);
    check({st(3'd0), st(3'd5)}, 4'b1010);
    nops(6);
    cmd(C_ACT, 3'd6, 14'h0100);
    cmd(C_ACT, 3'd7, 14'h0200);
    cmd(C_RD, 3'd6, 14'h0405);
    nops(3);
    cmd(C_RD, 3'd7, 14'h0009);
    check({illegal, st(3'd7)}, 3'b001);
    nops(8);
    cmd(C_PRE, 3'd0, 14'h0400);
    nops(6);
    r0 = ref_row;
    cmd(C_REF, 3'd2, 14'h3fff);
    check(ref_row, r0 + 13'h0001);
    setin(16'h0000, 2'b00, 3'h0, 1'b1, 1'b0);
    nops(2);
    // power-down entry: nop with clock gate low, all banks idle
    cmd(C_NOP, 3'h0, 14'h0000, 1'b0);
    check({term_on, lanes, term_pd}, 4'b1111);
    setin(16'h0000, 2'b00, 3'h0, 1'b1, 1'b1);
    nops(1);
    check(term_pd, 1'b0);
    cmd(C_REF, 3'h0, 14'h0000, 1'b0);
    check({self_ref, loop_on, term_on}, 3'b100);
    repeat (20) @(posedge core_clk);
    cmd(C_NOP, 3'h0, 14'h0000, 1'b1);
    check({self_ref, loop_on}, 2'b01);
    nops(4);
    results();
  end
endmodule
`default_nettype wire
